// ### pkg/pcl_pkg.sv
// Shared constants and types for the programmable pad cell bank.
// Assumes a 32-bit APB slave with byte addresses and one pad per bit.
package pcl_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          PCL_NP       = 8;
    localparam int          PCL_AW       = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_USED     = 8'h04;
    localparam logic [7:0]  OFF_OREG     = 8'h08;
    localparam logic [7:0]  OFF_IREG     = 8'h0C;
    localparam logic [7:0]  OFF_FRZ      = 8'h10;
    localparam logic [7:0]  OFF_PULL     = 8'h14;
    localparam logic [7:0]  OFF_PUSTR    = 8'h18;
    localparam logic [7:0]  OFF_LEDHC    = 8'h1C;
    localparam logic [7:0]  OFF_STAT     = 8'h20;
    localparam logic [7:0]  OFF_PINS     = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CTRL_CFG_BIT = 0;
    localparam int          STAT_POR_BIT = 0;
    localparam int          STAT_USR_BIT = 1;
    localparam int          STAT_HLD_BIT = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PU_3K3  = 2'h0,
        PU_6K8  = 2'h1,
        PU_10K  = 2'h2,
        PU_100K = 2'h3
    } pcl_pu_e;

    typedef enum logic [2:0] {
        ST_POR  = 3'h1,
        ST_PRE  = 3'h2,
        ST_USER = 3'h4
    } pcl_st_e;

    typedef struct packed {
        logic [PCL_NP-1:0]   used;
        logic [PCL_NP-1:0]   oreg;
        logic [PCL_NP-1:0]   ireg;
        logic [PCL_NP-1:0]   frz_sel;
        logic [PCL_NP-1:0]   pull_en;
        logic [PCL_NP-1:0]   led_hc;
        logic [2*PCL_NP-1:0] pu_str;
    } pcl_cfg_s;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_MASK     = 8'h00;
    localparam logic [15:0] RST_PUSTR    = 16'hFFFF;
    localparam pcl_cfg_s    PCL_CFG_RST  = '{RST_MASK, RST_MASK, RST_MASK, RST_MASK,
                                              RST_MASK, RST_MASK, RST_PUSTR};

endpackage

// ### hw/pcl_pad_bank.sv
// Bank of programmable pad cells with APB configuration registers.
// Assumes pins, the power-on-reset level and the two register clocks are
// asynchronous and are synchronised here; core signals share clk.
//
// Contract
// R1 - Each pad may route core output through an output register or directly.
// R2 - Asserted hold latches the input value and presents it instead of the pin.
// R3 - Before configuration every pad is high-impedance with weak pull-up on.
// R4 - User settings apply only after reset release and a finished configuration.
// R5 - Core logic is held inactive while power-on reset is asserted.
// R6 - After configuration unused pads have input blocked and pull-up off.
// R7 - Each pad has its own bus maintenance choice: weak pull-up or none.
// R8 - Pull-up strength is 3.3k, 6.8k, 10k or 100k; 100k by default.
// R9 - Without high-current drive an LED pin is an open-drain general I/O.
// R10 - Freeze acts on non-registered inputs only; bank-wide hold, per-pad select.
// R11 - Registered inputs freeze by holding their clock or clock enable low.
// R12 - A pad drives only while its output enable is asserted.
// R13 - The shared clock enable gates both input and output register captures.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pcl_pad_bank
#(
    parameter logic [pcl_pkg::PCL_NP-1:0] LED_MASK = 8'hE0
)
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pcl_pkg::PCL_AW-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output var  logic [31:0]                   prdata,
    output      logic                          pready,
    output      logic                          pslverr,
    input  wire logic                          por_pin,
    input  wire logic                          in_clk_pin,
    input  wire logic                          out_clk_pin,
    input  wire logic                          clock_en,
    input  wire logic                          hold_in,
    input  wire logic [pcl_pkg::PCL_NP-1:0]    core_dout,
    input  wire logic [pcl_pkg::PCL_NP-1:0]    core_oe,
    output var  logic [pcl_pkg::PCL_NP-1:0]    core_din,
    output var  logic                          core_run,
    input  wire logic [pcl_pkg::PCL_NP-1:0]    pad_in,
    output var  logic [pcl_pkg::PCL_NP-1:0]    pad_out,
    output var  logic [pcl_pkg::PCL_NP-1:0]    pad_oe,
    output var  logic [pcl_pkg::PCL_NP-1:0]    pad_pu_en,
    output var  logic [2*pcl_pkg::PCL_NP-1:0]  pad_pu_sel
);
    import pcl_pkg::*;

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0]        rst_sync_r;
    logic              rst_ok_n;
    localparam int     SW = PCL_NP + 3;
    // Synchronisers leave reset showing power-on reset asserted, so the core
    // cannot start before the real level of the pin has been sampled
    localparam logic [SW-1:0] SYNC_RST = {3'h1, {PCL_NP{1'b0}}};
    logic [SW-1:0]     sync1_r;
    logic [SW-1:0]     sync2_r;
    logic              in_clk_d_r;
    logic              out_clk_d_r;
    wire  [PCL_NP-1:0] pin_s   = sync2_r[PCL_NP-1:0];
    wire               por_s   = sync2_r[PCL_NP];
    wire               in_clk_s  = sync2_r[PCL_NP+1];
    wire               out_clk_s = sync2_r[PCL_NP+2];
    wire               in_stb  = in_clk_s & ~in_clk_d_r;
    wire               out_stb = out_clk_s & ~out_clk_d_r;

    assign rst_ok_n = rst_sync_r[1];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    always_ff @(posedge clk or negedge rst_ok_n)
    begin
        if (!rst_ok_n)
        begin
            sync1_r     <= SYNC_RST;
            sync2_r     <= SYNC_RST;
            in_clk_d_r  <= 1'b0;
            out_clk_d_r <= 1'b0;
        end
        else
        begin
            sync1_r     <= {out_clk_pin, in_clk_pin, por_pin, pad_in};
            sync2_r     <= sync1_r;
            in_clk_d_r  <= in_clk_s;
            out_clk_d_r <= out_clk_s;
        end
    end

    // ------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------
    pcl_st_e  st_r;
    pcl_st_e  st_nxt;
    logic     cfg_done_r;
    pcl_cfg_s cfg_r;
    wire      st_user = (st_r == ST_USER);

    always_comb
    begin
        case (st_r)
            ST_POR:  st_nxt = por_s ? ST_POR : ST_PRE;                  // R4
            ST_PRE:  st_nxt = por_s ? ST_POR : (cfg_done_r ? ST_USER : ST_PRE); // R4
            ST_USER: st_nxt = por_s ? ST_POR : ST_USER;
            default: st_nxt = ST_POR;
        endcase
    end

    always_ff @(posedge clk or negedge rst_ok_n)
    begin
        if (!rst_ok_n)
        begin
            st_r     <= ST_POR;
            core_run <= 1'b0;
        end
        else
        begin
            st_r     <= st_nxt;
            core_run <= ~por_s;                                          // R5
        end
    end

    // ------------------------------------------------------------
    // APB register access
    // ------------------------------------------------------------
    wire wr_en  = psel & penable & pwrite;
    wire setup  = psel & ~penable;
    wire sel_ctrl  = (paddr == OFF_CTRL);
    wire sel_used  = (paddr == OFF_USED);
    wire sel_oreg  = (paddr == OFF_OREG);
    wire sel_ireg  = (paddr == OFF_IREG);
    wire sel_frz   = (paddr == OFF_FRZ);
    wire sel_pull  = (paddr == OFF_PULL);
    wire sel_pustr = (paddr == OFF_PUSTR);
    wire sel_ledhc = (paddr == OFF_LEDHC);
    wire sel_stat  = (paddr == OFF_STAT);
    wire sel_pins  = (paddr == OFF_PINS);
    wire hit = sel_ctrl | sel_used | sel_oreg | sel_ireg | sel_frz | sel_pull
             | sel_pustr | sel_ledhc | sel_stat | sel_pins;
    wire [7:0]  pw8  = pwdata[7:0];
    wire [2:0]  stat = {hold_in, st_user, por_s};
    wire [31:0] rd_val =
          sel_ctrl  ? {31'h0, cfg_done_r}
        : sel_used  ? {24'h0, cfg_r.used}
        : sel_oreg  ? {24'h0, cfg_r.oreg}
        : sel_ireg  ? {24'h0, cfg_r.ireg}
        : sel_frz   ? {24'h0, cfg_r.frz_sel}
        : sel_pull  ? {24'h0, cfg_r.pull_en}
        : sel_pustr ? {16'h0, cfg_r.pu_str}
        : sel_ledhc ? {24'h0, cfg_r.led_hc}
        : sel_stat  ? {29'h0, stat}
        : sel_pins  ? {24'h0, pin_s}
        : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge clk or negedge rst_ok_n)
    begin
        if (!rst_ok_n)
        begin
            cfg_r      <= PCL_CFG_RST;
            cfg_done_r <= 1'b0;
            prdata     <= 32'h0;
        end
        else
        begin
            prdata <= setup ? rd_val : prdata;
            if (por_s)
                cfg_done_r <= 1'b0;                                      // R4
            else if (wr_en && sel_ctrl)
                cfg_done_r <= pwdata[CTRL_CFG_BIT];
            if (wr_en && sel_used)  cfg_r.used    <= pw8;
            if (wr_en && sel_oreg)  cfg_r.oreg    <= pw8;
            if (wr_en && sel_ireg)  cfg_r.ireg    <= pw8;
            if (wr_en && sel_frz)   cfg_r.frz_sel <= pw8;
            if (wr_en && sel_pull)  cfg_r.pull_en <= pw8;
            if (wr_en && sel_pustr) cfg_r.pu_str  <= pwdata[15:0];
            if (wr_en && sel_ledhc) cfg_r.led_hc  <= pw8;
        end
    end

    // ------------------------------------------------------------
    // Pad data path
    // ------------------------------------------------------------
    logic [PCL_NP-1:0]   in_q_r;
    logic [PCL_NP-1:0]   out_q_r;
    logic [PCL_NP-1:0]   frz_q_r;
    logic [PCL_NP-1:0]   frz_act;
    logic [PCL_NP-1:0]   od;
    logic [PCL_NP-1:0]   out_val;
    logic [PCL_NP-1:0]   din_nxt;
    logic [PCL_NP-1:0]   dout_nxt;
    logic [PCL_NP-1:0]   oe_nxt;
    logic [PCL_NP-1:0]   pu_en_nxt;
    logic [2*PCL_NP-1:0] pu_sel_nxt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_ok_n);

    genvar i;
    generate
        for (i = 0; i < PCL_NP; i++)
        begin : g_pad
            assign od[i]      = LED_MASK[i] & ~cfg_r.led_hc[i];              // R9
            assign out_val[i] = cfg_r.oreg[i] ? out_q_r[i] : core_dout[i];   // R1
            assign frz_act[i] = hold_in & cfg_r.frz_sel[i] & ~cfg_r.ireg[i]; // R10 R11
            assign din_nxt[i] = ~(st_user & cfg_r.used[i]) ? 1'b0            // R6
                              : cfg_r.ireg[i] ? in_q_r[i]
                              : frz_act[i] ? frz_q_r[i] : pin_s[i];          // R2
            assign oe_nxt[i]  = st_user & cfg_r.used[i] & core_oe[i]         // R3 R12
                              & ~(od[i] & out_val[i]);                       // R9
            assign dout_nxt[i] = st_user & cfg_r.used[i] & ~od[i] & out_val[i];
            assign pu_en_nxt[i] = st_user ? (cfg_r.used[i] & cfg_r.pull_en[i]) // R6 R7
                                : 1'b1;                                      // R3
            assign pu_sel_nxt[2*i+1:2*i] = st_user ? cfg_r.pu_str[2*i+1:2*i] // R8
                                         : PU_100K;                          // R3

            chk_oreg_path: assert property (st_user && cfg_r.used[i] && !od[i] // R1
                    && core_oe[i] |=> pad_out[i] == $past(out_val[i]) && pad_oe[i])
                else $error("pad output path mismatch");
            chk_hold_value: assert property (st_user && cfg_r.used[i] && frz_act[i] [*3] // R2
                    |-> core_din[i] == $past(core_din[i]))
                else $error("held input changed");
            chk_unused_off: assert property (st_user && !cfg_r.used[i] // R6
                    |=> !pad_pu_en[i] && !pad_oe[i] && !core_din[i])
                else $error("unused pad not blocked");
            chk_pull_sel: assert property (st_user && cfg_r.used[i] |=> // R7 R8
                    pad_pu_en[i] == $past(cfg_r.pull_en[i])
                    && pad_pu_sel[2*i+1:2*i] == $past(cfg_r.pu_str[2*i+1:2*i]))
                else $error("pull setting mismatch");
            chk_open_drain: assert property (od[i] |=> !pad_out[i]) // R9
                else $error("open-drain pad drove high");
            chk_oe_gate: assert property (!core_oe[i] |=> !pad_oe[i]) // R12
                else $error("pad driven without enable");
            chk_ireg_path: assert property (st_user && cfg_r.used[i] && cfg_r.ireg[i] // R10 R11
                    |=> core_din[i] == $past(in_q_r[i]))
                else $error("registered input not used");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_ok_n)
    begin
        if (!rst_ok_n)
        begin
            in_q_r     <= '0;
            out_q_r    <= '0;
            frz_q_r    <= '0;
            core_din   <= '0;
            pad_out    <= '0;
            pad_oe     <= '0;
            pad_pu_en  <= '1;
            pad_pu_sel <= RST_PUSTR;
        end
        else
        begin
            if (in_stb && clock_en)
                in_q_r <= pin_s;                                         // R13
            if (out_stb && clock_en)
                out_q_r <= core_dout;                                    // R13
            frz_q_r    <= (frz_q_r & frz_act) | (pin_s & ~frz_act);      // R2
            core_din   <= din_nxt;
            pad_out    <= dout_nxt;
            pad_oe     <= oe_nxt;
            pad_pu_en  <= pu_en_nxt;
            pad_pu_sel <= pu_sel_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks on bank-wide behaviour
    // ------------------------------------------------------------
    chk_precfg_state: assert property (!st_user |=> !$past(st_user) |-> // R3
            pad_oe == '0 && pad_pu_en == '1 && pad_pu_sel == RST_PUSTR)
        else $error("pre-configuration pad state wrong");
    chk_por_block: assert property (por_s |=> !st_user ##1 !st_user) // R4
        else $error("user settings during power-on reset");
    chk_core_idle: assert property ($rose(por_s) |=> !core_run) // R5
        else $error("core running during power-on reset");
    chk_run_idle: assert property (por_s |=> !core_run) // R5
        else $error("core running while power-on reset high");
    chk_precfg_din: assert property (!st_user |=> core_din == '0) // R4
        else $error("input passed before configuration");
    chk_ce_gate: assert property (!clock_en |=> $stable(in_q_r) && $stable(out_q_r)) // R13
        else $error("register updated without clock enable");

endmodule

`default_nettype wire

// ### tb/pcl_ext_dev.sv
// Model of the external devices wired to the pad bank pins.
// Assumes one pin per bit; the design drives a pin while its enable is high.
`timescale 1ns/1ps
`default_nettype none

module pcl_ext_dev
(
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pu_en,
    input  wire logic [7:0] drv_en,
    input  wire logic [7:0] drv_val,
    output var  logic [7:0] pad_in
);
    logic [7:0] last = 8'h00;

    // A floating pin with no pull-up shows the inverse of the level last put on it
    always @(pad_out or pad_oe or pad_pu_en or drv_en or drv_val)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pad_oe[i])
            begin
                pad_in[i] = pad_out[i];
                last[i]   = pad_out[i];
            end
            else if (drv_en[i])
            begin
                pad_in[i] = drv_val[i];
                last[i]   = drv_val[i];
            end
            else if (pad_pu_en[i])
            begin
                pad_in[i] = 1'b1;
                last[i]   = 1'b1;
            end
            else
                pad_in[i] = ~last[i];
        end
    end
endmodule

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the pad bank: APB master, pins and core side.
// Assumes the pad bank from hw/ and the pin model pcl_ext_dev.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pcl_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, por_pin, in_clk_pin, out_clk_pin;
    logic        clock_en, hold_in, pready, pslverr, core_run, e;
    logic [7:0]  paddr, core_dout, core_oe, core_din, pad_in, pad_out, pad_oe;
    logic [7:0]  pad_pu_en, drv_en, drv_val;
    logic [15:0] pad_pu_sel;
    logic [31:0] pwdata, prdata, q;
    int          miscompares = 0;
    int          n_checks = 0;

    pcl_pad_bank #(.LED_MASK(8'hE0)) pcl_pad_bank_inst (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_pin(por_pin),
        .in_clk_pin(in_clk_pin), .out_clk_pin(out_clk_pin), .clock_en(clock_en),
        .hold_in(hold_in), .core_dout(core_dout), .core_oe(core_oe), .core_din(core_din),
        .core_run(core_run), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pu_en(pad_pu_en), .pad_pu_sel(pad_pu_sel));

    pcl_ext_dev pcl_ext_dev_inst (.pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pu_en(pad_pu_en), .drv_en(drv_en), .drv_val(drv_val), .pad_in(pad_in));

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Capture strobe on the output (o=1) or input register clock pin
    task automatic pulse(input bit o);
        @(posedge clk);
        if (o)
            out_clk_pin <= 1'b1;
        else
            in_clk_pin <= 1'b1;
        repeat (4) @(posedge clk);
        out_clk_pin <= 1'b0;
        in_clk_pin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        settle(3);
        chk("pad_oe", 8'h00, pad_oe);
        chk("pad_pu_en", 8'hFF, pad_pu_en);
        chk("pad_pu_sel", 16'hFFFF, pad_pu_sel);
        chk("core_run", 1'b0, core_run);
        chk("pready", 1'b1, pready);
        apb(1'b0, OFF_PUSTR, 32'h0);
        chk("pustr", 32'h0000FFFF, q);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped err", 1'b1, e);
        chk("unmapped data", 32'h0, q);
        apb(1'b1, OFF_CTRL, 32'h1);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl in por", 32'h0, q);
        $display("test reset done");
    endtask

    task automatic t_por();
        @(posedge clk);
        por_pin <= 1'b0;
        settle(5);
        chk("core_run", 1'b1, core_run);
        chk("pad_oe pre", 8'h00, pad_oe);
        chk("pull pre", 8'hFF, pad_pu_en);
        $display("test por done");
    endtask

    task automatic t_cfg();
        @(posedge clk);
        core_oe <= 8'h00;
        apb(1'b1, OFF_USED, 32'h7F);
        apb(1'b1, OFF_PULL, 32'hD5);
        apb(1'b1, OFF_PUSTR, 32'hE4);
        apb(1'b1, OFF_FRZ, 32'h05);
        apb(1'b1, OFF_OREG, 32'h02);
        apb(1'b1, OFF_IREG, 32'h04);
        apb(1'b1, OFF_CTRL, 32'h1);
        settle(2);
        chk("pull", 8'h55, pad_pu_en);
        chk("pu_sel", 8'hE4, pad_pu_sel[7:0]);
        apb(1'b0, OFF_STAT, 32'h0);
        chk("user mode", 1'b1, q[STAT_USR_BIT]);
        $display("test config done");
    endtask

    task automatic t_out();
        @(posedge clk);
        core_oe <= 8'h21;
        core_dout <= 8'h01;
        settle(1);
        chk("oe5 oe0 out5 out0", 4'b1101, {pad_oe[5], pad_oe[0], pad_out[5], pad_out[0]});
        @(posedge clk);
        core_dout <= 8'h20;
        settle(1);
        chk("oe5 oe0", 2'b01, {pad_oe[5], pad_oe[0]});
        apb(1'b1, OFF_LEDHC, 32'h20);
        settle(1);
        chk("oe5 out5 drive", 2'b11, {pad_oe[5], pad_out[5]});
        @(posedge clk);
        core_oe <= 8'h00;
        settle(1);
        chk("oe0 off", 1'b0, pad_oe[0]);
        $display("test output done");
    endtask

    task automatic t_oreg();
        @(posedge clk);
        core_oe <= 8'h02;
        core_dout <= 8'h02;
        clock_en <= 1'b0;
        pulse(1'b1);
        settle(1);
        chk("oreg no enable", 1'b0, pad_out[1]);
        @(posedge clk);
        clock_en <= 1'b1;
        pulse(1'b1);
        settle(1);
        chk("oreg captured", 1'b1, pad_out[1]);
        $display("test output register done");
    endtask

    task automatic t_hold();
        @(posedge clk);
        core_oe <= 8'h00;
        drv_en <= 8'h8D;
        drv_val <= 8'h8D;
        settle(6);
        chk("din 3 0", 2'b11, {core_din[3], core_din[0]});
        chk("din unused", 1'b0, core_din[7]);
        @(posedge clk);
        hold_in <= 1'b1;
        settle(2);
        @(posedge clk);
        drv_val <= 8'h80;
        settle(6);
        chk("din held", 2'b01, {core_din[3], core_din[0]});
        $display("test hold done");
    endtask

    task automatic t_ireg();
        @(posedge clk);
        drv_val <= 8'h84;
        clock_en <= 1'b0;
        pulse(1'b0);
        settle(4);
        chk("ireg no enable", 1'b0, core_din[2]);
        @(posedge clk);
        clock_en <= 1'b1;
        pulse(1'b0);
        settle(4);
        chk("ireg captured", 1'b1, core_din[2]);
        $display("test input register done");
    endtask

    task automatic t_repor();
        @(posedge clk);
        por_pin <= 1'b1;
        settle(5);
        chk("pad_oe", 8'h00, pad_oe);
        chk("pull", 8'hFF, pad_pu_en);
        chk("core_run", 1'b0, core_run);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0, q);
        $display("test power-on again done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, in_clk_pin, out_clk_pin, clock_en, hold_in} = 7'h00;
        por_pin = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        core_oe = 8'hFF;
        core_dout = 8'hFF;
        drv_en = 8'h00;
        drv_val = 8'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_por();
        t_cfg();
        t_out();
        t_oreg();
        t_hold();
        t_ireg();
        t_repor();
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule

`default_nettype wire
